// ===== core/crb_pkg.sv
// Package with register map, field layout and timing constants for the clock, reset and boot block
package crb_pkg;
    // ==================================================
    // Register offsets
    localparam logic [15:0] CRB_ADDR_DEMOD_CTRL = 16'h002a;
    localparam logic [15:0] CRB_ADDR_CLK_DIV = 16'h002b;
    localparam logic [15:0] CRB_ADDR_PIN_OUT = 16'h002c;
    localparam logic [15:0] CRB_ADDR_CORE_RST = 16'h002d;
    localparam logic [15:0] CRB_ADDR_CHECKSUM = 16'h002e;
    localparam logic [15:0] CRB_ADDR_BOOT_STAT = 16'h002f;
    localparam logic [15:0] CRB_ADDR_COEF_FIRST = 16'h0010;
    localparam logic [15:0] CRB_ADDR_COEF_LAST = 16'h0027;
    localparam int CRB_NUM_COEF = 24;
    // ==================================================
    // Field positions
    localparam int CRB_IN_DIV_LSB = 2;
    localparam int CRB_IN_DIV_MSB = 4;
    localparam int CRB_REF_DIV_LSB = 0;
    localparam int CRB_REF_DIV_MSB = 1;
    localparam int CRB_PAD_EN_BIT = 0;
    localparam int CRB_CORE_RST_BIT = 0;
    localparam int CRB_STAT_FAIL_BIT = 2;
    localparam int CRB_STAT_PASS_BIT = 1;
    localparam int CRB_STAT_DONE_BIT = 0;
    localparam int CRB_PIN_SEL_BIT = 3;
    // ==================================================
    // Reset values
    localparam logic [7:0] CRB_RST_DEMOD = 8'h18;
    localparam logic [7:0] CRB_RST_CLK_DIV = 8'h02;
    localparam logic [7:0] CRB_RST_PIN_OUT = 8'h01;
    localparam logic [7:0] CRB_RST_CORE = 8'h00;
    localparam logic [7:0] CRB_READ_ZERO = 8'h00;
    // ==================================================
    // Divider codes
    localparam logic [2:0] CRB_IN_DIV_1 = 3'h0;
    localparam logic [2:0] CRB_IN_DIV_16 = 3'h1;
    localparam logic [2:0] CRB_IN_DIV_64 = 3'h2;
    localparam logic [2:0] CRB_IN_DIV_256 = 3'h4;
    localparam logic [1:0] CRB_REF_DIV_4 = 2'h1;
    localparam logic [1:0] CRB_REF_DIV_8 = 2'h2;
    localparam logic [8:0] CRB_CNT_1 = 9'h001;
    localparam logic [8:0] CRB_CNT_16 = 9'h010;
    localparam logic [8:0] CRB_CNT_64 = 9'h040;
    localparam logic [8:0] CRB_CNT_256 = 9'h100;
    localparam logic [3:0] CRB_HALF_4 = 4'h2;
    localparam logic [3:0] CRB_HALF_8 = 4'h4;
    // ==================================================
    // Boot timing
    localparam int CRB_BOOT_WAIT_CYCLES = 10000;
    localparam int CRB_BOOT_BYTES = 48;
    // ==================================================
    // Boot states
    typedef enum logic [1:0] {
        CRB_BOOT_IDLE,
        CRB_BOOT_DATA,
        CRB_BOOT_SUM,
        CRB_BOOT_END
    } crb_boot_e;
endpackage : crb_pkg

// ===== core/crb_clk_div.sv
// Input clock and reference clock dividers
module crb_clk_div
    import crb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic core_hold,
    input wire logic [2:0] input_clock_divider,
    input wire logic [1:0] ref_div,
    output logic sample_in_tick,
    output logic sample_out_tick,
    output logic ref_clk
);
    typedef struct packed {
        logic [8:0] in_cnt;
        logic [3:0] ref_cnt;
        logic tick;
        logic ref_q;
    } crb_div_s;

    crb_div_s st;
    crb_div_s next_st;
    logic [8:0] in_limit;
    logic [3:0] half;

    // ==================================================
    // Division decode
    function automatic logic [8:0] in_count(input logic [2:0] code);
        case (code)
            CRB_IN_DIV_16: in_count = CRB_CNT_16;
            CRB_IN_DIV_64: in_count = CRB_CNT_64;
            CRB_IN_DIV_256: in_count = CRB_CNT_256;
            default: in_count = CRB_CNT_1;
        endcase
    endfunction : in_count

    always_comb begin
        in_limit = in_count(input_clock_divider); // RULE_01
        half = (ref_div == CRB_REF_DIV_4) ? CRB_HALF_4 : CRB_HALF_8; // RULE_02
        next_st = st;
        next_st.tick = 1'b0;
        if (core_hold) begin // RULE_04
            next_st.in_cnt = '0;
            next_st.ref_cnt = '0;
            next_st.ref_q = 1'b0;
        end else begin
            if (st.in_cnt + 9'h001 >= in_limit) begin
                next_st.in_cnt = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.in_cnt = st.in_cnt + 9'h001;
            end
            if (st.tick) begin
                if (st.ref_cnt + 4'h1 >= half) begin
                    next_st.ref_cnt = '0;
                    next_st.ref_q = ~st.ref_q;
                end else begin
                    next_st.ref_cnt = st.ref_cnt + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sample_in_tick = st.tick;
    assign sample_out_tick = st.tick;
    assign ref_clk = st.ref_q;
endmodule : crb_clk_div

// ===== core/crb_boot.sv
// Boot sequencer computing the EEPROM checksum and status flags
module crb_boot
    import crb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic boot_start,
    input wire logic ee_valid,
    input wire logic [7:0] ee_data,
    output logic [7:0] checksum,
    output logic sum_fail,
    output logic sum_pass,
    output logic boot_done,
    output logic booting
);
    typedef struct packed {
        crb_boot_e state;
        logic [7:0] sum;
        logic [5:0] count;
        logic [13:0] timer;
        logic fail;
        logic pass;
        logic done;
    } crb_bt_s;

    crb_bt_s st;
    crb_bt_s next_st;

    always_comb begin
        next_st = st;
        case (st.state)
            CRB_BOOT_IDLE: begin
                if (boot_start) begin
                    next_st.state = CRB_BOOT_DATA;
                    next_st.sum = '0;
                    next_st.count = '0;
                    next_st.timer = '0;
                    next_st.fail = 1'b0;
                    next_st.pass = 1'b0;
                    next_st.done = 1'b0;
                end
            end
            CRB_BOOT_DATA: begin
                next_st.timer = st.timer + 14'h0001;
                if (ee_valid) begin
                    next_st.sum = st.sum + ee_data; // RULE_13 RULE_06
                    if (st.count == 6'(CRB_BOOT_BYTES - 1)) begin
                        next_st.state = CRB_BOOT_SUM;
                    end else begin
                        next_st.count = st.count + 6'h01;
                    end
                end
                if (st.timer == 14'(CRB_BOOT_WAIT_CYCLES - 1)) begin
                    next_st.state = CRB_BOOT_END; // RULE_09
                end
            end
            CRB_BOOT_SUM: begin
                next_st.timer = st.timer + 14'h0001;
                if (ee_valid) begin
                    next_st.fail = (ee_data != st.sum); // RULE_07
                    next_st.pass = (ee_data == st.sum); // RULE_08
                    next_st.done = 1'b1; // RULE_09
                    next_st.state = CRB_BOOT_END;
                end else if (st.timer == 14'(CRB_BOOT_WAIT_CYCLES - 1)) begin
                    next_st.state = CRB_BOOT_END;
                end
            end
            CRB_BOOT_END: begin
                next_st.state = CRB_BOOT_END;
            end
            default: begin
                next_st.state = CRB_BOOT_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign checksum = st.sum;
    assign sum_fail = st.fail;
    assign sum_pass = st.pass;
    assign boot_done = st.done;
    assign booting = (st.state == CRB_BOOT_DATA) || (st.state == CRB_BOOT_SUM);
endmodule : crb_boot

// ===== core/crb_regs.sv
// Clock, pin, core reset and boot status register bank
// Function
// [RULE_01] Input clock divided by 1, 16, 64 or 256 from field [4:2], default 000.
// [RULE_02] Reference clock is output rate over 4 or 8 from field [1:0], default 10.
// [RULE_03] Shared output pad driven only while pad enable bit is 1, reset 1.
// [RULE_04] Core reset bit holds core in reset, registers keep their values.
// [RULE_05] Setting or clearing core reset never starts an EEPROM load.
// [RULE_06] Eight-bit checksum over boot EEPROM bytes readable in checksum register.
// [RULE_07] Status bit 2 set when computed checksum differs from stored byte.
// [RULE_08] Status bit 1 set when computed checksum matches stored byte.
// [RULE_09] Status bit 0 is 1 after boot completes, 0 on timeout.
// [RULE_10] Host waits 10,000 clocks after boot start before reading completion bit.
// [RULE_11] Default coefficients loaded at reset; coefficient reads return zero.
// [RULE_12] Pin select 0 routes serial data out, 1 routes reference clock.
// [RULE_13] Checksum is modulo-256 sum of data bytes, excluding stored checksum.
module crb_regs
    import crb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic boot_start,
    input wire logic ee_valid,
    input wire logic [7:0] ee_data,
    input wire logic serial_data_out,
    output logic shared_pad_out,
    output logic shared_pad_drive_enable_n,
    output logic core_reset,
    output logic sample_in_tick,
    output logic [7:0] coef_out [CRB_NUM_COEF]
);
    // ==================================================
    // State
    typedef struct packed {
        logic [7:0] demod;
        logic [7:0] clk_div;
        logic [7:0] pin_out;
        logic [7:0] core;
        logic [7:0] rdata;
        logic pad;
        logic pad_oe_n;
        logic core_rst;
        logic in_tick;
    } crb_reg_s;

    crb_reg_s st;
    crb_reg_s next_st;
    logic [7:0] coef [CRB_NUM_COEF];
    logic [7:0] checksum;
    logic sum_fail;
    logic sum_pass;
    logic boot_done;
    logic tick_in;
    logic ref_clk;

    // ==================================================
    // Default coefficient table
    localparam logic [7:0] CRB_COEF_DEF [CRB_NUM_COEF] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h97, 8'h7e, 8'h88, 8'hc0, 8'h0f, 8'hc0,
        8'h0f, 8'hc0, 8'h0f, 8'h00, 8'he0, 8'h23, 8'h02, 8'h24
    };

    function automatic logic is_coef(input logic [15:0] a);
        is_coef = (a >= CRB_ADDR_COEF_FIRST) && (a <= CRB_ADDR_COEF_LAST);
    endfunction : is_coef

    // ==================================================
    // Sub blocks
    crb_clk_div u_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .core_hold(st.core_rst),
        .input_clock_divider(st.clk_div[CRB_IN_DIV_MSB:CRB_IN_DIV_LSB]),
        .ref_div(st.clk_div[CRB_REF_DIV_MSB:CRB_REF_DIV_LSB]),
        .sample_in_tick(tick_in),
        .sample_out_tick(),
        .ref_clk(ref_clk)
    );

    // Boot start comes only from its own input, never from core reset
    crb_boot u_boot (
        .sys_clk(sys_clk),
        .reset(reset),
        .boot_start(boot_start), // RULE_05
        .ee_valid(ee_valid),
        .ee_data(ee_data),
        .checksum(checksum),
        .sum_fail(sum_fail),
        .sum_pass(sum_pass),
        .boot_done(boot_done),
        .booting()
    );

    // ==================================================
    // Coefficient store
    genvar gi;
    generate
        for (gi = 0; gi < CRB_NUM_COEF; gi++) begin : g_coef
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    coef[gi] <= CRB_COEF_DEF[gi]; // RULE_11
                end else if (reg_wr && reg_addr == CRB_ADDR_COEF_FIRST + 16'(gi)) begin
                    coef[gi] <= reg_wdata;
                end
            end
            assign coef_out[gi] = coef[gi];
        end
    endgenerate

    // ==================================================
    // Register and pad logic
    always_comb begin
        next_st = st;
        if (reg_wr) begin
            case (reg_addr)
                CRB_ADDR_DEMOD_CTRL: next_st.demod = reg_wdata;
                CRB_ADDR_CLK_DIV: next_st.clk_div = reg_wdata; // RULE_01 RULE_02
                CRB_ADDR_PIN_OUT: next_st.pin_out = reg_wdata;
                CRB_ADDR_CORE_RST: next_st.core = reg_wdata;
                default: next_st.demod = st.demod;
            endcase
        end
        next_st.rdata = st.rdata;
        if (reg_rd) begin
            if (is_coef(reg_addr)) begin
                next_st.rdata = CRB_READ_ZERO; // RULE_11
            end else begin
                case (reg_addr)
                    CRB_ADDR_DEMOD_CTRL: next_st.rdata = st.demod;
                    CRB_ADDR_CLK_DIV: next_st.rdata = st.clk_div;
                    CRB_ADDR_PIN_OUT: next_st.rdata = st.pin_out;
                    CRB_ADDR_CORE_RST: next_st.rdata = st.core;
                    CRB_ADDR_CHECKSUM: next_st.rdata = checksum; // RULE_06
                    CRB_ADDR_BOOT_STAT: begin
                        next_st.rdata = CRB_READ_ZERO;
                        next_st.rdata[CRB_STAT_FAIL_BIT] = sum_fail; // RULE_07
                        next_st.rdata[CRB_STAT_PASS_BIT] = sum_pass; // RULE_08
                        next_st.rdata[CRB_STAT_DONE_BIT] = boot_done; // RULE_09
                    end
                    default: next_st.rdata = CRB_READ_ZERO;
                endcase
            end
        end
        next_st.core_rst = st.core[CRB_CORE_RST_BIT]; // RULE_04
        next_st.pad = st.demod[CRB_PIN_SEL_BIT] ? ref_clk : serial_data_out; // RULE_12
        next_st.pad_oe_n = ~st.pin_out[CRB_PAD_EN_BIT]; // RULE_03
        next_st.in_tick = tick_in;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st.demod <= CRB_RST_DEMOD;
            st.clk_div <= CRB_RST_CLK_DIV;
            st.pin_out <= CRB_RST_PIN_OUT;
            st.core <= CRB_RST_CORE;
            st.rdata <= CRB_READ_ZERO;
            st.pad <= 1'b0;
            st.pad_oe_n <= 1'b0;
            st.core_rst <= 1'b0;
            st.in_tick <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign shared_pad_out = st.pad;
    assign shared_pad_drive_enable_n = st.pad_oe_n;
    assign core_reset = st.core_rst;
    assign sample_in_tick = st.in_tick;
endmodule : crb_regs

// ===== tb/crb_regs_props.sv
// Checker for the clock, reset and boot register bank
module crb_regs_props
    import crb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic shared_pad_drive_enable_n,
    input wire logic core_reset,
    input wire logic [7:0] coef_out [CRB_NUM_COEF]
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ========
    // Assertions
    property p_follow(logic [15:0] a, logic q);
        logic v;
        (reg_wr && reg_addr == a, v = reg_wdata[0]) |-> ##2 q == v;
    endproperty
    sequence s_quiet;
        !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2);
    endsequence
    a_pad_enable_follow: assert property (p_follow(CRB_ADDR_PIN_OUT, !shared_pad_drive_enable_n))
        else $error("pad enable does not follow write");
    a_pad_enable_hold: assert property (s_quiet |=> $stable(shared_pad_drive_enable_n))
        else $error("pad enable changed without write");
    a_core_rst_follow: assert property (p_follow(CRB_ADDR_CORE_RST, core_reset))
        else $error("core reset does not follow write");
    a_core_rst_hold: assert property (s_quiet |=> $stable(core_reset))
        else $error("core reset changed without write");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_coef_read_zero: assert property (reg_rd && reg_addr inside {[CRB_ADDR_COEF_FIRST:CRB_ADDR_COEF_LAST]}
        |=> reg_rdata == CRB_READ_ZERO)
        else $error("coefficient read not zero");
    a_unmapped_zero: assert property (reg_rd && reg_addr > CRB_ADDR_BOOT_STAT |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_flags_exclusive: assert property (reg_rd && reg_addr == CRB_ADDR_BOOT_STAT
        |=> !(reg_rdata[2] && reg_rdata[1]))
        else $error("pass and fail both set");
    a_coef_steady: assert property (!reg_wr |=> $stable(coef_out[10]))
        else $error("coefficient changed without write");
    c_status_read: cover property (reg_rd && reg_addr == CRB_ADDR_BOOT_STAT);
    c_core_held: cover property (core_reset);
    c_pad_off: cover property (shared_pad_drive_enable_n);
endmodule : crb_regs_props

bind crb_regs crb_regs_props u_props (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .shared_pad_drive_enable_n(shared_pad_drive_enable_n), .core_reset(core_reset), .coef_out(coef_out));

// ===== tb/crb_eeprom_model.sv
// Boot memory model feeding data bytes then a checksum byte
module crb_eeprom_model
    import crb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic boot_start,
    input wire logic [1:0] mode,
    output logic ee_valid,
    output logic [7:0] ee_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sum;
    initial begin
        ee_valid = 1'b0;
        ee_data = 8'h00;
        forever begin
            @(posedge sys_clk iff boot_start === 1'b1);
            sum = 8'h00;
            if (mode != 2'h2) begin
                for (int i = 0; i <= CRB_BOOT_BYTES; i++) begin
                    // Alternates prompt and slow delivery
                    repeat (1 + i % 2) @(negedge sys_clk);
                    ee_valid = 1'b1;
                    ee_data = (i == CRB_BOOT_BYTES) ? sum ^ {7'h00, mode[0]} : 8'(i * 7 + 3);
                    sum = sum + ee_data;
                    @(negedge sys_clk);
                    ee_valid = 1'b0;
                    ee_data = ~ee_data;
                end
            end
        end
    end
endmodule : crb_eeprom_model

// ===== tb/crb_regs_test.sv
// Testbench for the clock, reset and boot register bank
module crb_regs_test
    import crb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset, reg_wr, reg_rd, boot_start, ee_valid, serial_data_out, pad_prev;
    logic shared_pad_out, shared_pad_drive_enable_n, core_reset, sample_in_tick;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, ee_data, sum;
    logic [7:0] coef_out [CRB_NUM_COEF];
    logic [1:0] mode;
    int n_fail, n_compared;
    logic [15:0] n_ev;
    logic [2:0] codes [4] = '{CRB_IN_DIV_1, CRB_IN_DIV_16, CRB_IN_DIV_64, CRB_IN_DIV_256};
    logic [8:0] divs [4] = '{CRB_CNT_1, CRB_CNT_16, CRB_CNT_64, CRB_CNT_256};
    crb_regs dut (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .boot_start(boot_start), .ee_valid(ee_valid),
        .ee_data(ee_data), .serial_data_out(serial_data_out), .shared_pad_out(shared_pad_out),
        .shared_pad_drive_enable_n(shared_pad_drive_enable_n), .core_reset(core_reset),
        .sample_in_tick(sample_in_tick), .coef_out(coef_out));
    crb_eeprom_model ee (.sys_clk(sys_clk), .boot_start(boot_start), .mode(mode), .ee_valid(ee_valid),
        .ee_data(ee_data));
    always #12.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) pad_prev <= shared_pad_out;
    // ========
    // Tasks
    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        @(negedge sys_clk);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        check("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask : rd
    task automatic wait_ev(input logic sel, output logic [15:0] n);
        n = 16'h0000;
        do begin
            @(negedge sys_clk);
            n++;
        end while (!(sel ? shared_pad_out !== pad_prev : sample_in_tick === 1'b1) && n < 16'h0258);
        if (n == 16'h0258) begin
            n_fail++;
            end_of_test();
        end
    endtask : wait_ev
    task automatic gap(input logic sel, input logic [15:0] e);
        logic [15:0] n;
        wait_ev(sel, n);
        wait_ev(sel, n);
        check("event gap", e, n);
    endtask : gap
    task automatic do_reset();
        reset = 1'b1;
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
    endtask : do_reset
    // ========
    // Main sequence
    initial begin
        {sys_clk, reg_wr, reg_rd, boot_start, serial_data_out, mode, reg_addr, reg_wdata} = '0;
        n_fail = 0;
        n_compared = 0;
        do_reset();
        rd(CRB_ADDR_CLK_DIV, CRB_RST_CLK_DIV);
        rd(CRB_ADDR_PIN_OUT, 8'h01);
        rd(CRB_ADDR_CORE_RST, 8'h00);
        rd(CRB_ADDR_COEF_FIRST, 8'h00);
        rd(CRB_ADDR_COEF_LAST, 8'h00);
        rd(16'h0030, 8'h00);
        check("coef_out", 16'h0097, {8'h00, coef_out[10]});
        check("coef_out", 16'h0024, {8'h00, coef_out[23]});
        wr(CRB_ADDR_COEF_FIRST + 16'h000a, 8'h5a);
        rd(CRB_ADDR_COEF_FIRST + 16'h000a, 8'h00);
        check("coef_out", 16'h005a, {8'h00, coef_out[10]});
        check("drive_enable_n", 16'h0000, {15'h0000, shared_pad_drive_enable_n});
        for (int k = 0; k < 4; k++) begin
            wr(CRB_ADDR_CLK_DIV, {3'h0, codes[k], 2'h2});
            rd(CRB_ADDR_CLK_DIV, {3'h0, codes[k], 2'h2});
            gap(1'b0, {7'h00, divs[k]});
        end
        wr(CRB_ADDR_DEMOD_CTRL, 8'h08);
        for (int r = 1; r < 4; r++) begin
            wr(CRB_ADDR_CLK_DIV, 8'(r));
            gap(1'b1, {12'h000, r == 1 ? CRB_HALF_4 : CRB_HALF_8});
        end
        wr(CRB_ADDR_DEMOD_CTRL, 8'h00);
        for (int b = 0; b < 2; b++) begin
            serial_data_out = ~b[0];
            repeat (3) @(negedge sys_clk);
            check("shared_pad_out", {15'h0000, ~b[0]}, {15'h0000, shared_pad_out});
        end
        wr(CRB_ADDR_PIN_OUT, 8'h00);
        repeat (3) @(negedge sys_clk);
        check("drive_enable_n", 16'h0001, {15'h0000, shared_pad_drive_enable_n});
        wr(CRB_ADDR_PIN_OUT, 8'h01);
        repeat (3) @(negedge sys_clk);
        check("drive_enable_n", 16'h0000, {15'h0000, shared_pad_drive_enable_n});
        wr(CRB_ADDR_CLK_DIV, 8'h06);
        wr(CRB_ADDR_CORE_RST, 8'h01);
        wr(CRB_ADDR_BOOT_STAT, 8'hff);
        check("core_reset", 16'h0001, {15'h0000, core_reset});
        n_ev = 16'h0000;
        repeat (40) @(negedge sys_clk) n_ev = n_ev + 16'(sample_in_tick);
        check("sample_in_tick", 16'h0000, n_ev);
        rd(CRB_ADDR_CLK_DIV, 8'h06);
        rd(CRB_ADDR_BOOT_STAT, 8'h00);
        wr(CRB_ADDR_CORE_RST, 8'h00);
        repeat (200) @(negedge sys_clk);
        check("core_reset", 16'h0000, {15'h0000, core_reset});
        gap(1'b0, {7'h00, CRB_CNT_16});
        rd(CRB_ADDR_BOOT_STAT, 8'h00);
        sum = 8'h00;
        for (int i = 0; i < CRB_BOOT_BYTES; i++) sum = sum + 8'(i * 7 + 3);
        for (int m = 0; m < 3; m++) begin
            do_reset();
            mode = 2'(m);
            boot_start = 1'b1;
            @(negedge sys_clk);
            boot_start = 1'b0;
            repeat (CRB_BOOT_WAIT_CYCLES + 20) @(negedge sys_clk);
            rd(CRB_ADDR_BOOT_STAT, m == 0 ? 8'h03 : m == 1 ? 8'h05 : 8'h00);
            if (m < 2) rd(CRB_ADDR_CHECKSUM, sum);
            if (m == 0) begin
                wr(CRB_ADDR_CORE_RST, 8'h01);
                wr(CRB_ADDR_CORE_RST, 8'h00);
                rd(CRB_ADDR_BOOT_STAT, 8'h03);
            end
        end
        end_of_test();
    end
endmodule : crb_regs_test
